// ==== hdl/stc_pkg.sv ====
package stc_pkg;

  // ****************************************
  // Register map (byte address = index * 4)
  // ****************************************
  localparam logic [7:0] IDX_INTCTL  = 8'h0b;
  localparam logic [7:0] IDX_FLAGS   = 8'h0c;
  localparam logic [7:0] IDX_CNT_LO  = 8'h0e;
  localparam logic [7:0] IDX_CNT_HI  = 8'h0f;
  localparam logic [7:0] IDX_CTRL    = 8'h10;
  localparam logic [7:0] IDX_ENABLES = 8'h8c;
  localparam logic [7:0] IDX_CMP_LO  = 8'h15;
  localparam logic [7:0] IDX_CMP_HI  = 8'h16;
  localparam logic [7:0] IDX_CCPMODE = 8'h17;
  localparam logic [7:0] IDX_PORTDIR = 8'h87;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int          CTRL_RUN_BIT   = 0;
  localparam int          CTRL_CS_BIT    = 1;
  localparam int          CTRL_SYNC_BIT  = 2;
  localparam int          CTRL_OSC_BIT   = 3;
  localparam int          CTRL_PS_LO     = 4;
  localparam logic [7:0]  CTRL_MASK      = 8'h3f;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [7:0]  FLAGS_RESET    = 8'h00;
  localparam logic [7:0]  ENABLES_RESET  = 8'h00;
  localparam logic [7:0]  INTCTL_RESET   = 8'h00;
  localparam logic [7:0]  PORTDIR_RESET  = 8'hff;
  localparam int          OVF_BIT        = 0;
  localparam logic [3:0]  CCP_SPECIAL    = 4'hb;
  localparam logic [15:0] CNT_MAX        = 16'hffff;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  localparam logic [1:0]  INSTR_DIV      = 2'h3;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } stc_apb_req_s;

  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  flags;
    logic [7:0]  enables;
    logic [7:0]  intctl;
    logic [7:0]  portdir;
    logic [3:0]  ccp_mode;
    logic [15:0] cmp;
    logic [15:0] count;
    logic [2:0]  pre_cnt;
    logic [1:0]  phase;
    logic        ext_s1;
    logic        ext_s2;
    logic        ext_prev;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        irq;
    logic        osc_run;
    logic        pin_oe_n0;
    logic        pin_oe_n1;
    logic        adc_start;
  } stc_state_s;

endpackage

// ==== hdl/stc_timer.sv ====
// Function
// - Clock source select bit picks timer or external count; sync bit splits count modes
// - Timer mode counts each instruction cycle after the prescaler
// - Counter mode counts rising edges of the external clock after the prescaler
// - Oscillator enabled forces both oscillator pins to inputs, ignoring direction bits
// - Counter has an internal reset input driven by the compare unit trigger
// - Prescale field 11=1:8, 10=1:4, 01=1:2, 00=1:1
// - Oscillator enable bit runs the crystal oscillator; clear shuts it off
// - Timer oscillator keeps running during sleep
// - Count wraps FFFFh to 0000h and sets the overflow flag
// - Interrupt raised only while overflow interrupt enable is set
// - Compare mode 1011 trigger resets the count and starts a conversion
// - Trigger reset never sets the overflow flag
// - Software write wins over a coincident trigger reset
// - Compare pair acts as the period in trigger mode
`timescale 1ns/100ps
`default_nettype none
module stc_timer
  import stc_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys_in,
  input  wire logic              reset_in,
  // APB slave
  input  wire stc_pkg::stc_apb_req_s apb_in,
  output logic                   pready_out,
  output logic                   pslverr_out,
  output logic [31:0]            prdata_out,
  // Link and system
  input  wire logic              ext_clock_pin_in,
  input  wire logic              sleep_in,
  output logic                   irq_out,
  output logic                   osc_run_out,
  output logic                   osc_in_pin_oe_n_out,
  output logic                   osc_out_pin_oe_n_out,
  output logic                   adc_start_out
);
  import stc_pkg::*;

  stc_state_s q;
  stc_state_s d;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [2:0] ps_mask(input logic [1:0] sel);
    ps_mask = 3'((4 << sel) - 4) >> 2 | 3'((1 << sel) - 1);
  endfunction

  function automatic logic [7:0] word_idx(input logic [31:0] addr);
    word_idx = addr[9:2];
  endfunction

  // Only these word indices answer without an error; the rest are refused
  function automatic logic is_mapped(input logic [7:0] i);
    case (i)
      IDX_CTRL, IDX_FLAGS, IDX_ENABLES, IDX_INTCTL, IDX_PORTDIR: begin
        is_mapped = 1'b1;
      end
      IDX_CMP_LO, IDX_CMP_HI, IDX_CCPMODE, IDX_CNT_LO, IDX_CNT_HI: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  logic       ext_src;
  logic       tick;
  logic       pre_out;
  logic       acc;
  logic       commit;
  logic [7:0] hw_set;
  logic       wr_lo;
  logic       wr_hi;
  logic       trig;
  logic [7:0] idx;
  logic [7:0] wb;
  logic [2:0] pmask;

  always_comb begin
    d        = q;
    idx      = word_idx(apb_in.paddr);
    wb       = apb_in.pwdata[7:0];
    acc      = apb_in.psel && apb_in.penable && !q.pready;
    // Writes land one edge later, where the master samples pready high
    commit   = apb_in.psel && apb_in.penable && q.pready;
    hw_set   = 8'h00;
    ext_src  = q.ctrl[CTRL_CS_BIT];
    pmask    = ps_mask(q.ctrl[CTRL_PS_LO +: 2]);
    // Synchroniser: s1 feeds only s2
    d.ext_s1 = ext_clock_pin_in;
    d.ext_s2 = q.ext_s1;
    // Bypass uses the raw pin but still sees it once per system clock
    d.ext_prev = q.ctrl[CTRL_SYNC_BIT] ? ext_clock_pin_in : q.ext_s2;
    d.phase  = q.phase + 2'd1;
    if (ext_src) begin
      tick = q.ctrl[CTRL_SYNC_BIT] ? (ext_clock_pin_in && !q.ext_prev)
                                   : (q.ext_s2 && !q.ext_prev);
    end else begin
      tick = (q.phase == INSTR_DIV) && !sleep_in;
    end
    pre_out = 1'b0;
    if (q.ctrl[CTRL_RUN_BIT] && tick) begin
      if ((q.pre_cnt & pmask) == pmask) begin
        d.pre_cnt = 3'h0;
        pre_out   = 1'b1;
      end else begin
        d.pre_cnt = q.pre_cnt + 3'h1;
      end
    end
    // Trigger only acts in compare-special mode on a match
    trig = (q.ccp_mode == CCP_SPECIAL) && (q.count == q.cmp) && pre_out;
    if (pre_out) begin
      d.count = q.count + 16'h0001;
      if (q.count == CNT_MAX && !trig) begin
        hw_set[OVF_BIT] = 1'b1;
      end
    end
    if (trig) begin
      d.count = CNT_ZERO;
    end
    d.adc_start = trig;
    // Kept apart so a hardware set survives a coincident clear
    d.flags = q.flags | hw_set;

    // ****************************************
    // Bus handshake
    // ****************************************
    // APB
    d.pready  = acc;
    d.pslverr = 1'b0;
    wr_lo = commit && apb_in.pwrite && idx == IDX_CNT_LO;
    wr_hi = commit && apb_in.pwrite && idx == IDX_CNT_HI;
    if (wr_lo) begin
      d.count[7:0] = wb;
    end
    if (wr_hi) begin
      d.count[15:8] = wb;
    end

    // ****************************************
    // Register reads
    // ****************************************
    // Answer and error code are registered at the taking edge
    if (acc) begin
      d.prdata  = 32'h0000_0000;
      d.pslverr = !is_mapped(idx);
      if (!apb_in.pwrite) begin
        unique case (idx)
          IDX_CTRL:    d.prdata[7:0] = q.ctrl;
          IDX_FLAGS:   d.prdata[7:0] = q.flags;
          IDX_ENABLES: d.prdata[7:0] = q.enables;
          IDX_INTCTL:  d.prdata[7:0] = q.intctl;
          IDX_PORTDIR: d.prdata[7:0] = q.portdir;
          IDX_CMP_LO:  d.prdata[7:0] = q.cmp[7:0];
          IDX_CMP_HI:  d.prdata[7:0] = q.cmp[15:8];
          IDX_CCPMODE: d.prdata[3:0] = q.ccp_mode;
          IDX_CNT_LO:  d.prdata[7:0] = q.count[7:0];
          IDX_CNT_HI:  d.prdata[7:0] = q.count[15:8];
          default:     d.prdata = 32'h0000_0000;
        endcase
      end
    end

    // ****************************************
    // Register writes
    // ****************************************
    // Refused indices fall to the default and change nothing
    if (commit && apb_in.pwrite) begin
      unique case (idx)
        IDX_CTRL:    d.ctrl = wb & CTRL_MASK;
        IDX_FLAGS:   d.flags = (q.flags & ~wb) | hw_set;
        IDX_ENABLES: d.enables = wb;
        IDX_INTCTL:  d.intctl = wb;
        IDX_PORTDIR: d.portdir = wb;
        IDX_CMP_LO:  d.cmp[7:0] = wb;
        IDX_CMP_HI:  d.cmp[15:8] = wb;
        IDX_CCPMODE: d.ccp_mode = wb[3:0];
        default:     d.pslverr = 1'b0;
      endcase
    end

    // ****************************************
    // Pins and interrupt
    // ****************************************
    // Sleep does not stop the crystal
    d.osc_run   = d.ctrl[CTRL_OSC_BIT];
    d.pin_oe_n0 = d.ctrl[CTRL_OSC_BIT] | d.portdir[0];
    d.pin_oe_n1 = d.ctrl[CTRL_OSC_BIT] | d.portdir[1];
    d.irq       = |(d.flags & d.enables & 8'h01);
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      q <= '0;
      q.ctrl      <= CTRL_RESET;
      q.flags     <= FLAGS_RESET;
      q.enables   <= ENABLES_RESET;
      q.intctl    <= INTCTL_RESET;
      q.portdir   <= PORTDIR_RESET;
      q.pin_oe_n0 <= 1'b1;
      q.pin_oe_n1 <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign pready_out           = q.pready;
  assign pslverr_out          = q.pslverr;
  assign prdata_out           = q.prdata;
  assign irq_out              = q.irq;
  assign osc_run_out          = q.osc_run;
  assign osc_in_pin_oe_n_out  = q.pin_oe_n1;
  assign osc_out_pin_oe_n_out = q.pin_oe_n0;
  assign adc_start_out        = q.adc_start;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  a_hold_stopped: assert property (!q.ctrl[CTRL_RUN_BIT] && !(wr_lo || wr_hi) && !trig
      |=> q.count == $past(q.count)) else $error("count moved while stopped");
  a_wrap_flag: assert property (pre_out && q.count == CNT_MAX && !trig && !wr_lo && !wr_hi
      |=> q.count == CNT_ZERO && q.flags[OVF_BIT]) else $error("wrap lost");
  a_irq_gate: assert property (!q.enables[OVF_BIT] |-> !irq_out)
      else $error("irq while disabled");
  a_trig_reset: assert property (trig && !wr_lo && !wr_hi |=> q.count == CNT_ZERO && adc_start_out)
      else $error("trigger reset missed");
  a_trig_noflag: assert property (trig && !q.flags[OVF_BIT] && !(commit && idx == IDX_FLAGS)
      |=> !q.flags[OVF_BIT]) else $error("trigger set flag");
  a_write_wins: assert property (trig && wr_lo |=> q.count[7:0] == $past(wb))
      else $error("write lost to trigger");
  a_pins_input: assert property (q.ctrl[CTRL_OSC_BIT] |-> osc_in_pin_oe_n_out
      && osc_out_pin_oe_n_out) else $error("osc pins driven");
  a_timer_rate: assert property (!ext_src && q.ctrl[CTRL_RUN_BIT] && !sleep_in
      && q.ctrl[CTRL_PS_LO +: 2] == 2'b00 && q.phase == INSTR_DIV && q.count != q.cmp
      && !wr_lo && !wr_hi |=> q.count == $past(q.count) + 16'h0001) else $error("timer rate");
  a_osc_follow: assert property (##1 osc_run_out == q.ctrl[CTRL_OSC_BIT])
      else $error("osc enable mismatch");


  a_pready_pulse: assert property (pready_out |=> !pready_out)
      else $error("pready held too long");

  a_take_answer: assert property (acc |=> pready_out)
      else $error("no answer after take");

  a_read_upper: assert property (pready_out |-> prdata_out[31:8] == 24'h00_0000)
      else $error("upper read bits set");

  a_unmapped_err: assert property (acc && !is_mapped(idx) |=> pslverr_out)
      else $error("unmapped index not refused");

  a_mapped_ok: assert property (acc && is_mapped(idx) |=> !pslverr_out)
      else $error("mapped index refused");

  a_unmapped_nowrite: assert property (commit && apb_in.pwrite && !is_mapped(idx)
      |=> q.ctrl == $past(q.ctrl) && q.enables == $past(q.enables))
      else $error("refused write landed");

  a_count_write: assert property (wr_lo && !wr_hi |=> q.count[7:0] == $past(wb))
      else $error("count low write lost");

  a_ctrl_upper: assert property (1'b1 |-> q.ctrl[7:6] == 2'b00)
      else $error("unimplemented control bits set");

  a_pre_hold: assert property (!q.ctrl[CTRL_RUN_BIT]
      |=> q.pre_cnt == $past(q.pre_cnt))
      else $error("prescaler moved while stopped");

  a_mode_select: assert property (!ext_src && q.phase != INSTR_DIV |-> !tick)
      else $error("timer tick off phase");

  a_sleep_stops: assert property (!ext_src && sleep_in |-> !tick)
      else $error("timer ticked in sleep");

  a_sleep_osc: assert property (sleep_in && q.ctrl[CTRL_OSC_BIT] |-> osc_run_out)
      else $error("oscillator stopped in sleep");

  a_osc_off: assert property (!q.ctrl[CTRL_OSC_BIT] |-> !osc_run_out)
      else $error("oscillator runs while off");

  a_ext_sync_cnt: assert property (ext_src && !q.ctrl[CTRL_SYNC_BIT]
      && q.ctrl[CTRL_RUN_BIT] && q.ctrl[CTRL_PS_LO +: 2] == 2'b00 && q.ext_s2 && !q.ext_prev
      && q.ccp_mode != CCP_SPECIAL && !wr_lo && !wr_hi |=> q.count == $past(q.count) + 16'h0001)
      else $error("synced edge not counted");

  a_ext_bypass_cnt: assert property (ext_src && q.ctrl[CTRL_SYNC_BIT]
      && q.ctrl[CTRL_RUN_BIT] && q.ctrl[CTRL_PS_LO +: 2] == 2'b00 && ext_clock_pin_in
      && !q.ext_prev && q.ccp_mode != CCP_SPECIAL && !wr_lo && !wr_hi
      |=> q.count == $past(q.count) + 16'h0001)
      else $error("bypassed edge not counted");

  a_ext_idle: assert property (ext_src && !tick && !wr_lo && !wr_hi
      |=> q.count == $past(q.count))
      else $error("count moved without an edge");

  a_flag_sticky: assert property (q.flags[OVF_BIT]
      && !(commit && apb_in.pwrite && idx == IDX_FLAGS) |=> q.flags[OVF_BIT])
      else $error("overflow flag dropped");

  a_flag_clear: assert property (q.flags[OVF_BIT] && commit && apb_in.pwrite
      && idx == IDX_FLAGS && wb[OVF_BIT] && !pre_out |=> !q.flags[OVF_BIT])
      else $error("overflow flag not cleared");

  a_set_wins: assert property (commit && apb_in.pwrite && idx == IDX_FLAGS
      && pre_out && q.count == CNT_MAX && !trig |=> q.flags[OVF_BIT])
      else $error("clear beat a new overflow");

  a_irq_level: assert property (1'b1
      |-> irq_out == (q.flags[OVF_BIT] && q.enables[OVF_BIT]))
      else $error("irq level wrong");

  a_adc_single: assert property (adc_start_out |=> !adc_start_out)
      else $error("conversion start too long");

  a_no_trig_mode: assert property (q.ccp_mode != CCP_SPECIAL |=> !adc_start_out)
      else $error("trigger outside special mode");

  a_period_wrap: assert property (q.ccp_mode == CCP_SPECIAL && pre_out
      && q.count == q.cmp && !wr_lo && !wr_hi |=> q.count == CNT_ZERO)
      else $error("period match did not restart");

  a_pins_follow: assert property (!q.ctrl[CTRL_OSC_BIT]
      |-> osc_in_pin_oe_n_out == q.portdir[1] && osc_out_pin_oe_n_out == q.portdir[0])
      else $error("pin direction ignored");

  c_sleep_count: cover property (ext_src && sleep_in && pre_out);
  c_flag_clear:  cover property (commit && apb_in.pwrite && idx == IDX_FLAGS && q.flags[OVF_BIT]);
  c_overflow: cover property (pre_out && q.count == CNT_MAX);
  c_trigger:  cover property (trig);
  c_ext_cnt:  cover property (ext_src && pre_out);
endmodule
`default_nettype wire

// ==== tb/stc_ext_clk_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module stc_ext_clk_model (
  // Clock and burst control
  input  wire logic clk_sys_in,
  input  wire logic run_in,
  // External count clock
  output var  logic ext_clock_pin_out
);
  logic [2:0] div_q = 3'h0;
  // Rests low between bursts; one edge per 8 clocks stays well inside what sampling resolves
  always @(posedge clk_sys_in) begin
    div_q <= run_in ? div_q + 3'h1 : 3'h0;
    ext_clock_pin_out <= run_in & div_q[2];
  end
  initial ext_clock_pin_out = 1'b0;
endmodule
`default_nettype wire

// ==== tb/tb_stc_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_stc_timer;
  import stc_pkg::*;
  logic         clk_sys = 1'b0;
  logic         reset = 1'b1;
  logic         ext_run = 1'b0;
  logic         sleep = 1'b0;
  stc_apb_req_s apb = '0;
  logic         pready, pslverr, irq, osc_run, oe_in_n, oe_out_n, adc_start, ext_pin, last_err;
  logic [31:0]  prdata, r;
  logic [7:0]   v;
  logic [7:0]   ridx[4] = '{IDX_CTRL, IDX_FLAGS, IDX_ENABLES, IDX_PORTDIR};
  logic [7:0]   rexp[4] = '{8'h00, 8'h00, 8'h00, 8'hff};
  int           n_mismatch = 0, samples_checked = 0, edges = 0, pulses = 0;

  always #25 clk_sys = ~clk_sys;
  always @(posedge ext_pin) edges++;
  always @(posedge clk_sys) if (adc_start === 1'b1) pulses++;

  stc_timer u_stc_timer (.clk_sys_in(clk_sys), .reset_in(reset), .apb_in(apb),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .ext_clock_pin_in(ext_pin), .sleep_in(sleep), .irq_out(irq), .osc_run_out(osc_run),
    .osc_in_pin_oe_n_out(oe_in_n), .osc_out_pin_oe_n_out(oe_out_n), .adc_start_out(adc_start));
  stc_ext_clk_model u_stc_ext_clk_model (.clk_sys_in(clk_sys), .run_in(ext_run),
    .ext_clock_pin_out(ext_pin));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Idle edge first so a released strobe is never raised again in the same step
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int i;
    @(posedge clk_sys);
    apb <= '{1'b1, 1'b0, wr, {22'h0, idx, 2'b00}, {24'h0, wd}};
    @(posedge clk_sys);
    apb.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      results();
    end
    r = prdata;
    last_err = pslverr;
    apb.psel <= 1'b0;
    apb.penable <= 1'b0;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h3193));
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (ridx[k]) begin
      xfer(1'b0, ridx[k], 8'h00);
      chk("reset value", r, {24'h0, rexp[k]});
    end
    xfer(1'b0, 8'h20, 8'h00);
    chk("unmapped error", last_err, 32'h1);
    repeat (4) begin
      v = 8'($urandom());
      xfer(1'b1, IDX_CNT_LO, v);
      xfer(1'b1, IDX_CNT_HI, ~v);
      xfer(1'b0, IDX_CNT_LO, 8'h00);
      chk("count low", r, {24'h0, v});
      xfer(1'b0, IDX_CNT_HI, 8'h00);
      chk("count high", r, {24'h0, ~v});
    end
    $display("done registers");
    for (int p = 0; p < 4; p++) begin
      xfer(1'b1, IDX_CNT_LO, 8'h00);
      xfer(1'b1, IDX_CNT_HI, 8'h00);
      xfer(1'b1, IDX_CTRL, {2'b00, 2'(p), 4'h5});
      repeat (128) @(posedge clk_sys);
      xfer(1'b1, IDX_CTRL, 8'h00);
      xfer(1'b0, IDX_CNT_LO, 8'h00);
      v = 8'(32 >> p);
      chk("prescaled count", (r[7:0] + 8'h1 - v) <= 8'h2, 32'h1);
      v = r[7:0];
      repeat (40) @(posedge clk_sys);
      xfer(1'b0, IDX_CNT_LO, 8'h00);
      chk("held count", r, {24'h0, v});
    end
    $display("done prescale");
    xfer(1'b1, IDX_PORTDIR, 8'h00);
    @(posedge clk_sys);
    chk("pins driven", {oe_in_n, oe_out_n}, 32'h0);
    for (int s = 0; s < 2; s++) begin
      xfer(1'b1, IDX_CNT_LO, 8'h00);
      xfer(1'b1, IDX_CTRL, {4'h0, 1'b1, 1'(s), 2'b11});
      repeat (40) @(posedge clk_sys);
      sleep <= 1'(s);
      edges = 0;
      ext_run <= 1'b1;
      repeat (80) @(posedge clk_sys);
      ext_run <= 1'b0;
      chk("pins released", {osc_run, oe_in_n, oe_out_n}, 32'h7);
      repeat (10) @(posedge clk_sys);
      sleep <= 1'b0;
      xfer(1'b0, IDX_CNT_LO, 8'h00);
      chk("edge count", r, 32'(edges));
    end
    $display("done counter");
    xfer(1'b1, IDX_CTRL, 8'h00);
    xfer(1'b1, IDX_ENABLES, 8'h01);
    xfer(1'b1, IDX_CNT_LO, 8'hfe);
    xfer(1'b1, IDX_CNT_HI, 8'hff);
    xfer(1'b1, IDX_CTRL, 8'h01);
    repeat (20) @(posedge clk_sys);
    xfer(1'b1, IDX_CTRL, 8'h00);
    chk("irq raised", irq, 32'h1);
    xfer(1'b0, IDX_CNT_HI, 8'h00);
    chk("wrapped high", r, 32'h0);
    xfer(1'b1, IDX_ENABLES, 8'h00);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    chk("overflow flag", r[0], 32'h1);
    chk("irq masked", irq, 32'h0);
    xfer(1'b1, IDX_FLAGS, 8'h01);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    chk("flag cleared", r[0], 32'h0);
    $display("done overflow");
    xfer(1'b1, IDX_CCPMODE, {4'h0, CCP_SPECIAL});
    xfer(1'b1, IDX_CMP_LO, 8'h05);
    xfer(1'b1, IDX_CMP_HI, 8'h00);
    xfer(1'b1, IDX_CNT_LO, 8'h00);
    xfer(1'b1, IDX_CTRL, 8'h01);
    pulses = 0;
    repeat (200) @(posedge clk_sys);
    xfer(1'b1, IDX_CTRL, 8'h00);
    chk("trigger pulses", pulses >= 6, 32'h1);
    xfer(1'b0, IDX_CNT_LO, 8'h00);
    chk("count bounded", r <= 32'h5, 32'h1);
    xfer(1'b0, IDX_FLAGS, 8'h00);
    chk("no flag", r[0], 32'h0);
    $display("done trigger");
    results();
  end
endmodule
`default_nettype wire
